// [src/trs_pkg.sv]
// Types of the tag read sequencer
package trs_pkg;
    typedef enum logic [5:0] {
        TRS_IDLE  = 6'b000001,
        TRS_READ  = 6'b000010,
        TRS_SENS  = 6'b000100,
        TRS_WAIT  = 6'b001000,
        TRS_BLINK = 6'b010000,
        TRS_HOLD  = 6'b100000
    } trs_seq_e;
    typedef enum logic [4:0] {
        TRS_TX_IDLE = 5'b00001,
        TRS_TX_PRE  = 5'b00010,
        TRS_TX_CODE = 5'b00100,
        TRS_TX_CHK  = 5'b01000,
        TRS_TX_SUF  = 5'b10000
    } trs_tx_e;
endpackage

// [src/trs_regs.svh]
// Register offsets, fields, reset values and timing counts of the tag read sequencer
`ifndef TRS_REGS_SVH
`define TRS_REGS_SVH
// ==========================================================
// Register offsets
`define TRS_CTRL_OFS     12'h000
`define TRS_WAIT_OFS     12'h004
`define TRS_DELAY_OFS    12'h008
`define TRS_TRIG_OFS     12'h00c
`define TRS_ADDR_OFS     12'h010
`define TRS_FIX_OFS      12'h014
`define TRS_STAT_OFS     12'h018
`define TRS_EVENT_OFS    12'h01c
`define TRS_EVCODE_OFS   12'h020
// ==========================================================
// Control fields
`define TRS_C_SEND       0
`define TRS_C_PREFIX     1
`define TRS_C_SUFFIX     2
`define TRS_C_CHECK      3
`define TRS_C_NEWONLY    4
`define TRS_C_DELAY      5
`define TRS_C_CICO       6
`define TRS_C_SENSOR     7
`define TRS_C_ALLMOV     8
`define TRS_C_SWTRIG     9
`define TRS_C_HWTRIG     10
`define TRS_C_LEDWAIT    11
`define TRS_C_RELWAIT    12
`define TRS_C_BUZWAIT    13
`define TRS_C_MIRROR     14
`define TRS_C_OUT2PWM    15
`define TRS_C_RELCONT    16
`define TRS_C_ANTON      17
`define TRS_C_READWAIT   18
`define TRS_C_ACCESS     19
`define TRS_C_FREE       20
`define TRS_CTRL_RST     32'h0012_2801
// ==========================================================
// Reset values and timing
`define TRS_WAIT_RST     16'h0001
`define TRS_DELAY_RST    16'h000a
`define TRS_TRIG_RST     16'h0001
`define TRS_ADDR_RST     8'h00
`define TRS_ADDR_MAX     8'hfe
`define TRS_FIX_RST      32'h0000_0d02
`define TRS_TICK_MS      100
`define TRS_CLK_KHZ      25000
`define TRS_TICK_CYC     (`TRS_TICK_MS * `TRS_CLK_KHZ)
`define TRS_BLINK_CYC    2500000
`define TRS_PWM_CYC      500000
`define TRS_PWM_HI       37500
`define TRS_ZERO_CHAR    8'h30
`define TRS_CR_CHAR      8'h0d
`endif

// [src/trs_top.sv]
// Tag read sequencer: read cycle control, code filter, frame sender, APB registers
`timescale 1ns/100ps
`include "trs_regs.svh"
module trs_top import trs_pkg::*; #(
    parameter int CODE_CHARS = 10,
    parameter int TICK_CYC   = `TRS_TICK_CYC,
    parameter int BLINK_CYC  = `TRS_BLINK_CYC,
    parameter int PWM_CYC    = `TRS_PWM_CYC,
    parameter int PWM_HI     = `TRS_PWM_HI
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cycle_done,
    input  wire logic        tag_valid,
    input  wire logic [63:0] tag_code,
    input  wire logic        tag_listed,
    input  wire logic        sensor_out,
    input  wire logic        sensor_in,
    input  wire logic        hw_trigger,
    input  wire logic        host_trigger,
    input  wire logic [7:0]  host_addr,
    output logic             cycle_start,
    output logic             antenna_on,
    output logic             led_on,
    output logic             relay1_on,
    output logic             out2_on,
    output logic             buzzer_on,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready
);
    // ==========================================================
    // Registers
    logic [31:0] ctrl_q;
    logic [15:0] wait_q, delay_q, trig_q;
    logic [7:0]  addr_q;
    logic [31:0] fix_q;
    logic [15:0] ev_cnt_q;
    logic [63:0] ev_code_q;
    logic        ev_pend_q;
    trs_seq_e    seq_q;
    trs_tx_e     tx_q;
    logic [63:0] last_q, send_q;
    logic        zero_q, zf_q;
    logic [15:0] rep_q, trig_left_q, wait_left_q, absent_q;
    logic [31:0] tick_q, blink_q, pwm_q;
    logic        blink_lvl_q, present_q, both_q, hit_q, busy_q;
    logic [3:0]  idx_q;
    logic [7:0]  chk_q;

    function automatic logic [7:0] code_char(input logic [63:0] c, input logic [3:0] i);
        logic [3:0] nib;
        nib = c[i*4 +: 4];
        code_char = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
    endfunction

    wire wr = psel && penable && pwrite;
    wire own_addr = (host_addr == addr_q);
    wire trig_ev = (ctrl_q[`TRS_C_SWTRIG] && host_trigger && own_addr)
                 || (ctrl_q[`TRS_C_HWTRIG] && hw_trigger);
    wire free_run = ctrl_q[`TRS_C_FREE];
    wire sens = ctrl_q[`TRS_C_SENSOR];
    wire any_sens = sensor_out || sensor_in;
    wire same = tag_valid && (tag_code == last_q);
    wire accept = tag_valid && !(same && (ctrl_q[`TRS_C_NEWONLY] || ctrl_q[`TRS_C_CICO]))
                  && !(same && ctrl_q[`TRS_C_DELAY] && rep_q < delay_q);
    wire reading = (seq_q == TRS_READ) || (seq_q == TRS_SENS && !hit_q)
                 || (seq_q == TRS_WAIT && ctrl_q[`TRS_C_READWAIT]);
    wire tick = (tick_q == 32'(TICK_CYC - 1));
    wire tx_go = !busy_q && ctrl_q[`TRS_C_SEND] && (accept || zero_q) && tx_q == TRS_TX_IDLE;

    // ==========================================================
    // APB slave
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q  <= `TRS_CTRL_RST;
            wait_q  <= `TRS_WAIT_RST;
            delay_q <= `TRS_DELAY_RST;
            trig_q  <= `TRS_TRIG_RST;
            addr_q  <= `TRS_ADDR_RST;
            fix_q   <= `TRS_FIX_RST;
        end else if (wr) begin
            unique case (paddr)
                `TRS_CTRL_OFS:  ctrl_q  <= pwdata;
                `TRS_WAIT_OFS:  wait_q  <= (pwdata[15:0] > 16'd250) ? 16'd250 : pwdata[15:0];
                `TRS_DELAY_OFS: delay_q <= pwdata[15:0];
                `TRS_TRIG_OFS:  trig_q  <= pwdata[15:0];
                `TRS_ADDR_OFS: begin
                    if (pwdata[7:0] != 8'hff) addr_q <= pwdata[7:0];
                end
                `TRS_FIX_OFS:   fix_q   <= pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                unique case (paddr)
                    `TRS_CTRL_OFS:   prdata <= ctrl_q;
                    `TRS_WAIT_OFS:   prdata <= {16'h0, wait_q};
                    `TRS_DELAY_OFS:  prdata <= {16'h0, delay_q};
                    `TRS_TRIG_OFS:   prdata <= {16'h0, trig_q};
                    `TRS_ADDR_OFS:   prdata <= {24'h0, addr_q};
                    `TRS_FIX_OFS:    prdata <= fix_q;
                    `TRS_STAT_OFS:   prdata <= {24'h0, ev_pend_q, present_q, seq_q};
                    `TRS_EVENT_OFS:  prdata <= {16'h0, ev_cnt_q};
                    `TRS_EVCODE_OFS: prdata <= ev_code_q[31:0];
                    default: begin
                        prdata  <= 32'h0;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Read sequence
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            seq_q       <= TRS_IDLE;
            trig_left_q <= 16'h0;
            wait_left_q <= 16'h0;
            tick_q      <= 32'h0;
            both_q      <= 1'b0;
            hit_q       <= 1'b0;
        end else begin
            tick_q <= tick ? 32'h0 : tick_q + 32'h1;
            unique case (seq_q)
                TRS_IDLE: begin
                    hit_q  <= 1'b0;
                    both_q <= 1'b0;
                    if (sens && any_sens) seq_q <= TRS_SENS;
                    else if (trig_ev) begin
                        trig_left_q <= trig_q;
                        seq_q       <= TRS_READ;
                    end else if (free_run && !sens) seq_q <= TRS_READ;
                end
                TRS_READ: begin
                    if (tag_valid) begin
                        seq_q       <= TRS_WAIT;
                        wait_left_q <= wait_q;
                    end else if (cycle_done) begin
                        if (trig_left_q > 16'h1) trig_left_q <= trig_left_q - 16'h1;
                        else if (!free_run || trig_left_q == 16'h1) seq_q <= TRS_IDLE;
                        if (trig_left_q == 16'h1) trig_left_q <= 16'h0;
                    end
                end
                TRS_SENS: begin
                    if (tag_valid) hit_q <= 1'b1;
                    if (sensor_out && sensor_in) both_q <= 1'b1;
                    if ((hit_q || tag_valid) && (both_q || (sensor_out && sensor_in))) begin
                        seq_q       <= TRS_WAIT;
                        wait_left_q <= wait_q;
                    end else if (!any_sens) seq_q <= TRS_IDLE;
                end
                TRS_WAIT: begin
                    if (tick) wait_left_q <= wait_left_q - 16'h1;
                    if (wait_left_q == 16'h0)
                        seq_q <= (sens && any_sens) ? TRS_BLINK : TRS_IDLE;
                end
                TRS_BLINK: if (!any_sens) seq_q <= TRS_IDLE;
                TRS_HOLD:  seq_q <= TRS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Code filter and event memory
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            last_q    <= 64'h0;
            rep_q     <= 16'h0;
            present_q <= 1'b0;
            absent_q  <= 16'h0;
            zero_q    <= 1'b0;
            ev_cnt_q  <= 16'h0;
            ev_code_q <= 64'h0;
            ev_pend_q <= 1'b0;
        end else begin
            zero_q <= 1'b0;
            if (tag_valid) begin
                last_q    <= tag_code;
                rep_q     <= (same && rep_q < delay_q) ? rep_q : 16'h0;
                present_q <= 1'b1;
                absent_q  <= 16'h0;
            end else if (cycle_done) begin
                if (rep_q != 16'hffff) rep_q <= rep_q + 16'h1;
                if (present_q) begin
                    if (absent_q >= delay_q) begin
                        present_q <= 1'b0;
                        // Only check-in forgets the code; new-only must see another code first
                        if (ctrl_q[`TRS_C_CICO]) last_q <= 64'h0;
                        zero_q    <= ctrl_q[`TRS_C_CICO];
                    end else absent_q <= absent_q + 16'h1;
                end
            end
            ev_pend_q <= 1'b0;
            if (seq_q == TRS_SENS && !any_sens) begin
                if (both_q || ctrl_q[`TRS_C_ALLMOV]) begin
                    ev_cnt_q  <= ev_cnt_q + 16'h1;
                    ev_code_q <= 64'h0;
                    ev_pend_q <= 1'b1;
                end
            end else if (seq_q == TRS_SENS && hit_q && both_q) begin
                ev_code_q <= last_q;
            end else if (seq_q == TRS_WAIT && sens && wait_left_q == 16'h0) begin
                ev_cnt_q  <= ev_cnt_q + 16'h1;
                ev_code_q <= last_q;
                ev_pend_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Frame sender: prefix, code, check char, suffix
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_q     <= TRS_TX_IDLE;
            tx_valid <= 1'b0;
            tx_data  <= 8'h0;
            idx_q    <= 4'h0;
            chk_q    <= 8'h0;
            send_q   <= 64'h0;
            busy_q   <= 1'b0;
            zf_q     <= 1'b0;
        end else begin
            if (tx_valid && tx_ready) tx_valid <= 1'b0;
            if (tx_go) begin
                // Host shares the line, so a busy frame drops new codes
                busy_q <= 1'b1;
                zf_q   <= zero_q;
                send_q <= zero_q ? 64'h0 : tag_code;
                idx_q  <= 4'h0;
                chk_q  <= 8'h0;
                tx_q   <= ctrl_q[`TRS_C_PREFIX] && !zero_q ? TRS_TX_PRE : TRS_TX_CODE;
            end else if (!tx_valid || tx_ready) begin
                unique case (tx_q)
                    TRS_TX_IDLE: busy_q <= 1'b0;
                    TRS_TX_PRE: begin
                        tx_data  <= fix_q[7:0];
                        tx_valid <= 1'b1;
                        tx_q     <= TRS_TX_CODE;
                    end
                    TRS_TX_CODE: begin
                        tx_data  <= zf_q ? `TRS_ZERO_CHAR
                                    : code_char(send_q, 4'(CODE_CHARS - 1) - idx_q);
                        chk_q    <= chk_q ^ code_char(send_q, 4'(CODE_CHARS - 1) - idx_q);
                        tx_valid <= 1'b1;
                        idx_q    <= idx_q + 4'h1;
                        // Absence frame is nine zeros, then CR from the suffix step
                        if (zf_q && idx_q == 4'h8)
                            tx_q <= TRS_TX_SUF;
                        else if (idx_q == 4'(CODE_CHARS - 1))
                            tx_q <= ctrl_q[`TRS_C_CHECK] ? TRS_TX_CHK
                                  : (ctrl_q[`TRS_C_SUFFIX] ? TRS_TX_SUF : TRS_TX_IDLE);
                    end
                    TRS_TX_CHK: begin
                        tx_data  <= chk_q;
                        tx_valid <= 1'b1;
                        tx_q     <= ctrl_q[`TRS_C_SUFFIX] ? TRS_TX_SUF : TRS_TX_IDLE;
                    end
                    TRS_TX_SUF: begin
                        tx_data  <= zf_q ? `TRS_CR_CHAR : fix_q[15:8];
                        tx_valid <= 1'b1;
                        tx_q     <= TRS_TX_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Actuators
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cycle_start <= 1'b0;
            antenna_on  <= 1'b0;
            led_on      <= 1'b0;
            relay1_on   <= 1'b0;
            out2_on     <= 1'b0;
            buzzer_on   <= 1'b0;
            blink_q     <= 32'h0;
            blink_lvl_q <= 1'b0;
            pwm_q       <= 32'h0;
        end else begin
            cycle_start <= reading && ctrl_q[`TRS_C_ANTON];
            antenna_on  <= reading && ctrl_q[`TRS_C_ANTON];
            if (blink_q == 32'(BLINK_CYC - 1)) begin
                blink_q     <= 32'h0;
                blink_lvl_q <= !blink_lvl_q;
            end else blink_q <= blink_q + 32'h1;
            pwm_q <= (pwm_q == 32'(PWM_CYC - 1)) ? 32'h0 : pwm_q + 32'h1;
            led_on <= (seq_q == TRS_BLINK) ? blink_lvl_q
                    : (seq_q == TRS_WAIT && ctrl_q[`TRS_C_LEDWAIT]);
            buzzer_on <= seq_q == TRS_WAIT && ctrl_q[`TRS_C_BUZWAIT];
            relay1_on <= ctrl_q[`TRS_C_RELCONT]
                       || (seq_q == TRS_WAIT && ctrl_q[`TRS_C_RELWAIT])
                       || (ctrl_q[`TRS_C_CICO] && ctrl_q[`TRS_C_RELWAIT] && present_q
                           && (!ctrl_q[`TRS_C_ACCESS] || tag_listed));
            out2_on <= ctrl_q[`TRS_C_OUT2PWM] ? (pwm_q < 32'(PWM_HI))
                     : (ctrl_q[`TRS_C_MIRROR] && relay1_on);
        end
    end
endmodule // trs_top

// [verif/tb_top.sv]
// Self-checking bench for the tag read sequencer
`timescale 1ns/100ps
`include "trs_regs.svh"
module tb_top;
    logic        core_clk, resetn, psel, penable, pwrite, cycle_done, tag_valid, hw_trigger, host_trigger;
    logic        cycle_start, antenna_on, led_on, relay1_on, out2_on, buzzer_on, tx_valid, tx_ready, pready;
    logic        pslverr, slow, er, hit, tag_listed, sensor_out, sensor_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] tag_code;
    logic [7:0]  host_addr, tx_data, x;
    logic [7:0]  exp_q[$];
    logic [3:0]  cyc_n;
    int          fail_count, n_compared;
    trs_top #(.TICK_CYC(10), .BLINK_CYC(4), .PWM_CYC(20), .PWM_HI(2)) i_trs_top (.core_clk, .resetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cycle_done, .tag_valid, .tag_code,
        .tag_listed, .sensor_out, .sensor_in, .hw_trigger, .host_trigger, .host_addr,
        .cycle_start, .antenna_on, .led_on, .relay1_on, .out2_on, .buzzer_on, .tx_valid, .tx_data, .tx_ready);
    trs_host_model i_trs_host_model (.core_clk, .resetn, .slow, .tx_valid, .tx_data, .tx_ready);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Reader stand-in: a read cycle ends every eight clocks while one runs
    always @(posedge core_clk) begin
        cyc_n <= cyc_n + 4'h1;
        cycle_done <= cycle_start === 1'b1 && cyc_n[2:0] == 3'h7;
    end
    // ==========================================================
    // Tasks
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic timed_out(input string what);
        fail_count++;
        $display("Error %s expected completion seen timeout", what);
        test_done();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) timed_out("pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic send_tag(input logic [39:0] c);
        int n;
        for (n = 0; n < 400 && antenna_on !== 1'b1; n++) @(posedge core_clk);
        if (n == 400) timed_out("antenna_on");
        tag_valid <= 1'b1;
        tag_code <= {24'h0, c};
        @(posedge core_clk);
        tag_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("led wait", 32'h1, {31'h0, led_on});
        chk("buzzer wait", 32'h1, {31'h0, buzzer_on});
        repeat (78) @(posedge core_clk);
    endtask
    // Only decimal digits used, so letter case of hex output never matters
    task automatic exp_code(input logic [39:0] c);
        for (int i = 9; i >= 0; i--) exp_q.push_back(8'h30 + {4'h0, c[i*4 +: 4]});
    endtask
    task automatic check_rx(input string what);
        int n;
        for (n = 0; n < 2000 && i_trs_host_model.rx_q.size() < exp_q.size(); n++) @(posedge core_clk);
        if (n == 2000) timed_out(what);
        repeat (20) @(posedge core_clk);
        chk({what, " count"}, 32'(exp_q.size()), 32'(i_trs_host_model.rx_q.size()));
        foreach (exp_q[i]) if (i < i_trs_host_model.rx_q.size()) chk(what, exp_q[i], i_trs_host_model.rx_q[i]);
        exp_q.delete();
        i_trs_host_model.rx_q.delete();
        $display("Test %s done", what);
    endtask
    task automatic pulse(input logic hw, input logic [7:0] a);
        host_addr <= a;
        hw_trigger <= hw;
        host_trigger <= !hw;
        @(posedge core_clk);
        hw_trigger <= 1'b0;
        host_trigger <= 1'b0;
        hit = 1'b0;
        repeat (30) begin
            @(posedge core_clk);
            if (cycle_start === 1'b1) hit = 1'b1;
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {resetn, psel, penable, pwrite, tag_valid, hw_trigger, host_trigger, slow, cycle_done} = '0;
        {paddr, pwdata, tag_code, host_addr, cyc_n} = '0;
        {tag_listed, sensor_out, sensor_in} = '0;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        rchk(`TRS_CTRL_OFS, 32'h0012_2801, "ctrl reset");
        rchk(`TRS_WAIT_OFS, 32'h0000_0001, "wait reset");
        rchk(`TRS_ADDR_OFS, 32'h0, "unit addr reset");
        rchk(12'h040, 32'h0, "unmapped data");
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'b1, `TRS_ADDR_OFS, 32'h0000_00fe);
        rchk(`TRS_ADDR_OFS, 32'h0000_00fe, "unit addr max");
        apb(1'b1, `TRS_ADDR_OFS, 32'h0000_00ff);
        rchk(`TRS_ADDR_OFS, 32'h0000_00fe, "unit addr ff");
        $display("Test registers done");
        exp_code(40'h1234567890);
        send_tag(40'h1234567890);
        check_rx("plain frame");
        apb(1'b1, `TRS_CTRL_OFS, 32'h0012_280f);
        apb(1'b1, `TRS_WAIT_OFS, 32'h0000_0001);
        slow <= 1'b1;
        exp_q.push_back(8'h02);
        exp_code(40'h0987654321);
        x = 8'h0;
        for (int i = 1; i <= 10; i++) x = x ^ exp_q[i];
        exp_q.push_back(x);
        exp_q.push_back(8'h0d);
        send_tag(40'h0987654321);
        check_rx("framed");
        slow <= 1'b0;
        apb(1'b1, `TRS_CTRL_OFS, 32'h0012_2811);
        send_tag(40'h1111111111);
        send_tag(40'h1111111111);
        send_tag(40'h2222222222);
        send_tag(40'h1111111111);
        exp_code(40'h1111111111);
        exp_code(40'h2222222222);
        exp_code(40'h1111111111);
        check_rx("new only");
        apb(1'b1, `TRS_CTRL_OFS, 32'h0012_2800);
        send_tag(40'h3333333333);
        check_rx("send off");
        apb(1'b1, `TRS_DELAY_OFS, 32'h0000_0014);
        apb(1'b1, `TRS_WAIT_OFS, 32'h0000_0001);
        apb(1'b1, `TRS_CTRL_OFS, 32'h001a_3841);
        tag_listed <= 1'b1;
        exp_code(40'h4444444444);
        send_tag(40'h4444444444);
        chk("checkin relay", 32'h1, {31'h0, relay1_on});
        repeat (9) exp_q.push_back(`TRS_ZERO_CHAR);
        exp_q.push_back(`TRS_CR_CHAR);
        check_rx("check in out");
        chk("checkout relay", 32'h0, {31'h0, relay1_on});
        apb(1'b1, `TRS_CTRL_OFS, 32'h0002_2881);
        repeat (20) @(posedge core_clk);
        {sensor_out, sensor_in} <= 2'b11;
        exp_code(40'h5555555555);
        send_tag(40'h5555555555);
        x = 8'h0;
        repeat (16) begin
            @(posedge core_clk);
            x = x + {7'h0, led_on};
        end
        chk("led blink", 32'h8, {24'h0, x});
        {sensor_out, sensor_in} <= 2'b00;
        check_rx("sensor frame");
        rchk(`TRS_EVCODE_OFS, 32'h5555_5555, "event code");
        {sensor_out, sensor_in} <= 2'b11;
        repeat (10) @(posedge core_clk);
        {sensor_out, sensor_in} <= 2'b00;
        repeat (5) @(posedge core_clk);
        rchk(`TRS_EVENT_OFS, 32'h2, "event count");
        rchk(`TRS_EVCODE_OFS, 32'h0, "null code");
        apb(1'b1, `TRS_CTRL_OFS, 32'h0002_2201);
        repeat (30) @(posedge core_clk);
        pulse(1'b0, 8'h05);
        chk("foreign trigger", 32'h0, {31'h0, hit});
        pulse(1'b0, 8'hfe);
        chk("host trigger", 32'h1, {31'h0, hit});
        apb(1'b1, `TRS_CTRL_OFS, 32'h0002_2401);
        repeat (30) @(posedge core_clk);
        pulse(1'b1, 8'h00);
        chk("hw trigger", 32'h1, {31'h0, hit});
        $display("Test triggers done");
        apb(1'b1, `TRS_CTRL_OFS, 32'h0011_4000);
        repeat (20) @(posedge core_clk);
        chk("relay cont", 32'h1, {31'h0, relay1_on});
        chk("out2 mirror", 32'h1, {31'h0, out2_on});
        chk("antenna off", 32'h0, {31'h0, antenna_on});
        $display("Test outputs done");
        test_done();
    end
endmodule // tb_top

// [verif/trs_host_model.sv]
// Serial-side host model: byte sink that can stall
`timescale 1ns/100ps
module trs_host_model (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       slow,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic [7:0] rx_q[$];
    logic [1:0] div_q;
    // Stalls three of four cycles when slow, to stress byte holding
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            tx_ready <= !slow || div_q == 2'h2;
        end
    end
    always @(posedge core_clk) begin
        if (resetn && tx_valid === 1'b1 && tx_ready) rx_q.push_back(tx_data);
    end
endmodule // trs_host_model

// [verif/trs_monitor.sv]
// Checker of bus, stream and output relations at the tag read sequencer ports
`timescale 1ns/100ps
`include "trs_regs.svh"
module trs_monitor (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        antenna_on,
    input wire logic        relay1_on,
    input wire logic        out2_on,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_ready
);
    // ==========================================================
    // Shadow of control word, seen only through bus writes
    logic [31:0] ctl_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctl_q <= `TRS_CTRL_RST;
        end else if (psel && penable && pready && pwrite && paddr == `TRS_CTRL_OFS) begin
            ctl_q <= pwdata;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // Assertions
    apb_no_wait_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    err_zero_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response with data");
    tx_byte_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte dropped before ready");
    no_send_off_a: assert property (!ctl_q[`TRS_C_SEND] ##1 !ctl_q[`TRS_C_SEND] |=> !$rose(tx_valid))
        else $error("frame started with sending off");
    antenna_off_a: assert property (!ctl_q[`TRS_C_ANTON] ##1 !ctl_q[`TRS_C_ANTON] |=> !antenna_on)
        else $error("antenna driven while disabled");
    relay_cont_a: assert property (ctl_q[`TRS_C_RELCONT] ##1 ctl_q[`TRS_C_RELCONT] |=> relay1_on)
        else $error("relay released in continuous mode");
    out2_mirror_a: assert property ((ctl_q[`TRS_C_MIRROR] && !ctl_q[`TRS_C_OUT2PWM] && $stable(relay1_on))[*3]
        |-> out2_on == relay1_on)
        else $error("output two not following relay");
    cover property (tx_valid && tx_ready);
    cover property (pslverr);
    cover property (ctl_q[`TRS_C_MIRROR] && out2_on);
endmodule // trs_monitor
bind trs_top trs_monitor i_trs_monitor (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .antenna_on, .relay1_on, .out2_on, .tx_valid, .tx_data, .tx_ready);
